// *** hdl/snp_map.vh ***
// Constants for the serial NOR array protection block.
`ifndef SNP_MAP_VH
`define SNP_MAP_VH
`define SNP_ADDR_W 21
`define SNP_SECT_LSB 16
`define SNP_SUB32_LSB 15
`define SNP_SUB4_LSB 12
`define SNP_PAGE_LSB 8
`define SNP_NUM_SECT 32
`define SNP_OTP_BYTES 64
`define SNP_OTP_ADDR_W 6
`define SNP_ERASED_BYTE 8'hFF
// APB register byte addresses.
`define SNP_REG_CTRL 12'h000
`define SNP_REG_STATUS 12'h004
`define SNP_REG_LOCK 12'h008
`define SNP_REG_LOCKDN 12'h00C
`define SNP_REG_CMD 12'h010
`define SNP_REG_RESULT 12'h014
`define SNP_REG_ADDR 12'h018
`define SNP_REG_DATA 12'h01C
// Control register fields.
`define SNP_CTRL_BP_LSB 0
`define SNP_CTRL_TB_BIT 3
`define SNP_CTRL_WP_BIT 4
// Command codes written to the command register.
`define SNP_CMD_WREN 4'h1
`define SNP_CMD_WRDI 4'h2
`define SNP_CMD_PROG 4'h3
`define SNP_CMD_ERASE4 4'h4
`define SNP_CMD_ERASE32 4'h5
`define SNP_CMD_ERASE64 4'h6
`define SNP_CMD_BULK 4'h7
`define SNP_CMD_WRLOCK 4'h8
`define SNP_CMD_WRSR 4'h9
`define SNP_CMD_PAGEERASE 4'hA
`define SNP_CMD_OTPPROG 4'hB
// Result codes.
`define SNP_RES_NONE 3'h0
`define SNP_RES_OK 3'h1
`define SNP_RES_NOWEL 3'h2
`define SNP_RES_FRAME 3'h3
`define SNP_RES_PROT 3'h4
`define SNP_RES_POWERUP 3'h5
`define SNP_RES_BADCMD 3'h6
`define SNP_RES_LOCKED 3'h7
// Power-up protection interval in microseconds.
`define SNP_PU_US 100
`define SNP_CLK_MHZ 20
`endif

// *** hdl/snp_bp_decode.v ***
// Block-protect range decoder giving a protected-sector mask.
`timescale 1ns/100ps
`default_nettype none
module snp_bp_decode #(
   parameter NSECT = 32
) (
   input wire [2:0] protect_size,
   input wire protect_from_bottom,
   output reg [NSECT-1:0] prot_mask
);
   reg [NSECT-1:0] low_mask;
   integer idx;
   always @* begin
      case (protect_size)
         3'h0: low_mask = {NSECT{1'b0}};
         3'h1: low_mask = {{(NSECT-1){1'b0}}, 1'b1};
         3'h2: low_mask = {{(NSECT-2){1'b0}}, 2'h3};
         3'h3: low_mask = {{(NSECT-4){1'b0}}, 4'hF};
         3'h4: low_mask = {{(NSECT-8){1'b0}}, 8'hFF};
         3'h5: low_mask = {{(NSECT/2){1'b0}}, {(NSECT/2){1'b1}}};
         default: low_mask = {NSECT{1'b1}};
      endcase
      // Top protection is the bottom mask mirrored.
      prot_mask = low_mask;
      if (!protect_from_bottom) begin
         prot_mask = {NSECT{1'b0}};
         for (idx = 0; idx < NSECT; idx = idx + 1) begin
            prot_mask[idx] = low_mask[NSECT-1-idx];
         end
      end
   end
endmodule
`default_nettype wire

// *** hdl/snp_addr_decode.v ***
// Address decoder splitting a byte address into array regions.
`timescale 1ns/100ps
`include "snp_map.vh"
`default_nettype none
module snp_addr_decode #(
   parameter AW = 21
) (
   input wire [AW-1:0] addr,
   output wire [AW-`SNP_SECT_LSB-1:0] sector,
   output wire [AW-`SNP_SUB32_LSB-1:0] sub32,
   output wire [AW-`SNP_SUB4_LSB-1:0] sub4,
   output wire [AW-`SNP_PAGE_LSB-1:0] page
);
   assign sector = addr[AW-1:`SNP_SECT_LSB];
   assign sub32 = addr[AW-1:`SNP_SUB32_LSB];
   assign sub4 = addr[AW-1:`SNP_SUB4_LSB];
   assign page = addr[AW-1:`SNP_PAGE_LSB];
endmodule
`default_nettype wire

// *** hdl/snp_protect.v ***
// Write-protection checker for the serial NOR array, with APB registers.
//
// Contract
// - Programming only clears bits; zeros stay zero.
// - Erase returns every byte of the region to all ones.
// - Erase exists for 4KB, 32KB, 64KB and whole array, never a page.
// - Array is 2 MB, 32 sectors of 64KB, 21-bit byte address.
// - 512 subsectors of 4KB and 8192 pages of 256 bytes.
// - A 64-byte one-time area lies outside the main array.
// - Sector, 32KB and 4KB indices come from upper address bits.
// - Modifying commands need a whole number of bytes of clocks.
// - Modifying commands need the write enable latch set first.
// - No modifying command runs during the power-up protection interval.
// - A set sector write-lock bit rejects program and erase.
// - A set lock-down bit freezes the sector state until reset.
// - Lock bits change only by lock write, never when locked down.
// - Top selection: codes protect none, 31, 30-31, 28-31, 24-31, 16-31, all.
// - Bottom selection: codes protect none, 0, 0-1, 0-3, 0-7, 0-15, all.
// - Write-protect pin low freezes block-protect and bottom-select bits.
`timescale 1ns/100ps
`include "snp_map.vh"
`default_nettype none
module snp_protect #(
   parameter AW = `SNP_ADDR_W,
   parameter NSECT = `SNP_NUM_SECT,
   parameter PU_CYCLES = `SNP_PU_US * `SNP_CLK_MHZ
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire wp_n,
   output reg cmd_grant,
   output reg [3:0] grant_cmd,
   output reg [AW-1:0] grant_addr,
   output reg [AW-1:0] grant_last,
   output reg [7:0] grant_data,
   output reg grant_otp,
   output reg powerup_busy
);
   ////////////////////////////////////////////////////////////////////////
   reg [2:0] protect_size;
   reg protect_from_bottom;
   reg wel;
   reg [NSECT-1:0] lock_bits;
   reg [NSECT-1:0] lockdn_bits;
   reg [AW-1:0] op_addr;
   reg [7:0] op_data;
   reg [2:0] last_result;
   reg [15:0] pu_cnt;
   wire [NSECT-1:0] bp_mask;
   wire [AW-`SNP_SECT_LSB-1:0] op_sector;
   wire [AW-`SNP_SUB32_LSB-1:0] op_sub32;
   wire [AW-`SNP_SUB4_LSB-1:0] op_sub4;
   wire [AW-`SNP_PAGE_LSB-1:0] op_page;
   wire wr_acc = psel && penable && pwrite;
   wire rd_sel = psel && !pwrite;
   wire hit_cmd = wr_acc && (paddr == `SNP_REG_CMD);
   wire hit_addr = wr_acc && (paddr == `SNP_REG_ADDR);
   wire hit_data = wr_acc && (paddr == `SNP_REG_DATA);
   wire hit_lockdn = wr_acc && (paddr == `SNP_REG_LOCKDN);
   wire [3:0] cmd = pwdata[3:0];
   // Bits 10:8 of a command word carry the clock count modulo eight.
   wire frame_ok = (pwdata[10:8] == 3'h0);
   // The counter is sixteen bits wide, so the interval tops out near
   // sixty-five thousand cycles.
   localparam [15:0] PU_LAST = PU_CYCLES[15:0] - 16'h0001;
   assign pready = 1'b1;
   // Only the eight register words decode; any other word errors and a
   // write to it is dropped.
   reg mapped;
   always @* begin
      case (paddr)
         `SNP_REG_CTRL: mapped = 1'b1;
         `SNP_REG_STATUS: mapped = 1'b1;
         `SNP_REG_LOCK: mapped = 1'b1;
         `SNP_REG_LOCKDN: mapped = 1'b1;
         `SNP_REG_CMD: mapped = 1'b1;
         `SNP_REG_RESULT: mapped = 1'b1;
         `SNP_REG_ADDR: mapped = 1'b1;
         `SNP_REG_DATA: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   ////////////////////////////////////////////////////////////////////////
   snp_bp_decode #(.NSECT(NSECT)) u_bp (
      .protect_size(protect_size),
      .protect_from_bottom(protect_from_bottom),
      .prot_mask(bp_mask)
   );
   snp_addr_decode #(.AW(AW)) u_addr (
      .addr(op_addr),
      .sector(op_sector),
      .sub32(op_sub32),
      .sub4(op_sub4),
      .page(op_page)
   );

   ////////////////////////////////////////////////////////////////////////
   // Range of the operation and the sectors it touches.
   reg [AW-1:0] next_first;
   reg [AW-1:0] next_last;
   reg [NSECT-1:0] touch;
   reg modifying;
   reg known;
   always @* begin
      next_first = op_addr;
      next_last = op_addr;
      touch = {NSECT{1'b0}};
      touch[op_sector] = 1'b1;
      modifying = 1'b1;
      known = 1'b1;
      case (cmd)
         `SNP_CMD_PROG: begin
            next_first = {op_page, {`SNP_PAGE_LSB{1'b0}}};
            next_last = {op_page, {`SNP_PAGE_LSB{1'b1}}};
         end
         `SNP_CMD_ERASE4: begin
            next_first = {op_sub4, {`SNP_SUB4_LSB{1'b0}}};
            next_last = {op_sub4, {`SNP_SUB4_LSB{1'b1}}};
         end
         `SNP_CMD_ERASE32: begin
            next_first = {op_sub32, {`SNP_SUB32_LSB{1'b0}}};
            next_last = {op_sub32, {`SNP_SUB32_LSB{1'b1}}};
         end
         `SNP_CMD_ERASE64: begin
            next_first = {op_sector, {`SNP_SECT_LSB{1'b0}}};
            next_last = {op_sector, {`SNP_SECT_LSB{1'b1}}};
         end
         `SNP_CMD_BULK: begin
            next_first = {AW{1'b0}};
            next_last = {AW{1'b1}};
            touch = {NSECT{1'b1}};
         end
         `SNP_CMD_OTPPROG: begin
            // The one-time area has no sector, so only the latch and the power-up interval guard it.
            next_first = {{(AW-`SNP_OTP_ADDR_W){1'b0}},
               op_addr[`SNP_OTP_ADDR_W-1:0]};
            next_last = next_first;
            touch = {NSECT{1'b0}};
         end
         `SNP_CMD_WRLOCK, `SNP_CMD_WRSR: begin
            // These change protection, not data, so no sector is touched.
            touch = {NSECT{1'b0}};
         end
         `SNP_CMD_WREN, `SNP_CMD_WRDI: begin
            modifying = 1'b0;
         end
         default: begin
            // Page erase falls here: the array offers no such operation.
            known = 1'b0;
            modifying = 1'b0;
         end
      endcase
   end

   // Bulk erase touches every sector, so one protected sector refuses it.
   wire sect_blocked = |(touch & (lock_bits | bp_mask));
   wire lock_frozen = lockdn_bits[op_sector];
   wire sr_frozen = !wp_n;

   // Checks run in a fixed priority; the first failing one is reported.
   reg [2:0] next_result;
   always @* begin
      if (!known) begin
         next_result = `SNP_RES_BADCMD;
      end else if (!frame_ok) begin
         next_result = `SNP_RES_FRAME;
      end else if (!modifying) begin
         next_result = `SNP_RES_OK;
      end else if (powerup_busy) begin
         next_result = `SNP_RES_POWERUP;
      end else if (!wel) begin
         next_result = `SNP_RES_NOWEL;
      end else if (sect_blocked) begin
         next_result = `SNP_RES_PROT;
      end else if ((cmd == `SNP_CMD_WRLOCK && lock_frozen) ||
            (cmd == `SNP_CMD_WRSR && sr_frozen)) begin
         next_result = `SNP_RES_LOCKED;
      end else begin
         next_result = `SNP_RES_OK;
      end
   end
   wire exec_ok = hit_cmd && known && (next_result == `SNP_RES_OK);
   // Array operations are the only commands handed to the far side.
   reg array_op;
   always @* begin
      case (cmd)
         `SNP_CMD_PROG, `SNP_CMD_ERASE4, `SNP_CMD_ERASE32: array_op = 1'b1;
         `SNP_CMD_ERASE64, `SNP_CMD_BULK, `SNP_CMD_OTPPROG: array_op = 1'b1;
         default: array_op = 1'b0;
      endcase
   end
   // A framed enable sets the latch; every known modifying command, taken
   // or refused, drops it, so each change needs a fresh enable.
   reg next_wel;
   always @* begin
      next_wel = wel;
      if (hit_cmd && cmd == `SNP_CMD_WREN && frame_ok) begin
         next_wel = 1'b1;
      end else if (hit_cmd && (modifying || cmd == `SNP_CMD_WRDI)) begin
         next_wel = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Every register here is reset by the synchronous reset alone; powerup_busy sets and op_data and grant_data load all ones.
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         protect_size <= 3'h0;
         protect_from_bottom <= 1'b0;
         wel <= 1'b0;
         lock_bits <= {NSECT{1'b0}};
         lockdn_bits <= {NSECT{1'b0}};
         op_addr <= {AW{1'b0}};
         op_data <= `SNP_ERASED_BYTE;
         last_result <= `SNP_RES_NONE;
         pu_cnt <= 16'h0000;
         powerup_busy <= 1'b1;
         cmd_grant <= 1'b0;
         grant_cmd <= 4'h0;
         grant_addr <= {AW{1'b0}};
         grant_last <= {AW{1'b0}};
         grant_data <= `SNP_ERASED_BYTE;
         grant_otp <= 1'b0;
      end else begin
         cmd_grant <= 1'b0;
         if (powerup_busy) begin
            pu_cnt <= pu_cnt + 16'h0001;
            if (pu_cnt == PU_LAST) begin
               powerup_busy <= 1'b0;
            end
         end
         if (hit_addr) begin
            op_addr <= pwdata[AW-1:0];
         end
         if (hit_data) begin
            op_data <= pwdata[7:0];
         end
         if (hit_lockdn) begin
            // Lock-down bits can only be set; only reset clears them.
            lockdn_bits <= lockdn_bits | pwdata[NSECT-1:0];
         end
         wel <= next_wel;
         if (hit_cmd) begin
            last_result <= next_result;
         end
         if (exec_ok && cmd == `SNP_CMD_WRLOCK) begin
            lock_bits[op_sector] <= op_data[0];
         end
         if (exec_ok && cmd == `SNP_CMD_WRSR) begin
            protect_size <= op_data[`SNP_CTRL_BP_LSB+2:`SNP_CTRL_BP_LSB];
            protect_from_bottom <= op_data[`SNP_CTRL_TB_BIT];
         end
         if (exec_ok && array_op) begin
            cmd_grant <= 1'b1;
            grant_cmd <= cmd;
            grant_addr <= next_first;
            grant_last <= next_last;
            grant_otp <= (cmd == `SNP_CMD_OTPPROG);
            // Erase writes all ones; a program only ever clears bits.
            if (cmd == `SNP_CMD_PROG || cmd == `SNP_CMD_OTPPROG) begin
               grant_data <= op_data;
            end else begin
               grant_data <= `SNP_ERASED_BYTE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data is forced to zero outside a read so the bus idles quietly.
   always @* begin
      prdata = 32'h00000000;
      if (rd_sel) begin
         case (paddr)
            `SNP_REG_CTRL: begin
               prdata[`SNP_CTRL_BP_LSB+2:`SNP_CTRL_BP_LSB] = protect_size;
               prdata[`SNP_CTRL_TB_BIT] = protect_from_bottom;
               prdata[`SNP_CTRL_WP_BIT] = sr_frozen;
            end
            `SNP_REG_STATUS: begin
               prdata[0] = powerup_busy;
               prdata[1] = wel;
            end
            `SNP_REG_LOCK: prdata[NSECT-1:0] = lock_bits;
            `SNP_REG_LOCKDN: prdata[NSECT-1:0] = lockdn_bits;
            `SNP_REG_RESULT: prdata[2:0] = last_result;
            `SNP_REG_ADDR: prdata[AW-1:0] = op_addr;
            `SNP_REG_DATA: prdata[7:0] = op_data;
            default: prdata = 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** testbench/snp_protect_chk.sv ***
// Assertion checker for the array protection block.
`timescale 1ns/100ps
`include "snp_map.vh"
`default_nettype none
module snp_protect_chk #(
   parameter PU_CYCLES = 8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic cmd_grant,
   input wire logic [3:0] grant_cmd,
   input wire logic [20:0] grant_addr,
   input wire logic [20:0] grant_last,
   input wire logic [7:0] grant_data,
   input wire logic grant_otp,
   input wire logic powerup_busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire logic cmd_wr = psel && penable && pwrite && paddr == `SNP_REG_CMD;
   property p_src; cmd_grant |-> $past(cmd_wr); endproperty
   a_src: assert property (p_src) else $error("grant without command");
   property p_frame; cmd_wr && pwdata[10:8] != 3'h0 |=> !cmd_grant; endproperty
   a_frame: assert property (p_frame) else $error("unframed grant");
   property p_pu; cmd_wr && powerup_busy |=> !cmd_grant; endproperty
   a_pu: assert property (p_pu) else $error("grant in power-up");
   property p_once; cmd_grant |=> !cmd_grant [*3]; endproperty
   a_once: assert property (p_once) else $error("grant repeated");
   property p_nopg; cmd_grant |-> grant_cmd != `SNP_CMD_PAGEERASE; endproperty
   a_nopg: assert property (p_nopg) else $error("page erase granted");
   property p_ff; cmd_grant && grant_cmd inside {[4'h4:4'h7]} |->
      grant_data == 8'hFF; endproperty
   a_ff: assert property (p_ff) else $error("erase data not ones");
   property p_page; cmd_grant && grant_cmd == 4'h3 |->
      grant_last == {grant_addr[20:8], 8'hFF}; endproperty
   a_page: assert property (p_page) else $error("page range");
   property p_sub4; cmd_grant && grant_cmd == 4'h4 |->
      grant_last == {grant_addr[20:12], 12'hFFF}; endproperty
   a_sub4: assert property (p_sub4) else $error("4KB range");
   property p_sect; cmd_grant && grant_cmd == 4'h6 |->
      grant_last == {grant_addr[20:16], 16'hFFFF}; endproperty
   a_sect: assert property (p_sect) else $error("sector range");
   property p_otp; cmd_grant && grant_otp |-> grant_addr[20:6] == 15'h0;
   endproperty
   a_otp: assert property (p_otp) else $error("one-time area address");
   c_grant: cover property (cmd_grant);
   c_bulk: cover property (cmd_grant && grant_cmd == 4'h7);
   c_otp: cover property (cmd_grant && grant_otp);
endmodule
bind snp_protect snp_protect_chk #(.PU_CYCLES(PU_CYCLES)) i_snp_protect_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cmd_grant(cmd_grant),
   .grant_cmd(grant_cmd), .grant_addr(grant_addr), .grant_last(grant_last),
   .grant_data(grant_data), .grant_otp(grant_otp),
   .powerup_busy(powerup_busy));
`default_nettype wire

// *** testbench/snp_host_model.sv ***
// Host model issuing register transfers to the block.
`timescale 1ns/100ps
`default_nettype none
module snp_host_model (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   int tmo = 0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // Released data is inverted so a stale word never passes for a request.
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) tmo++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the array protection block.
`timescale 1ns/100ps
`include "snp_map.vh"
`default_nettype none
module tb_top;
   typedef struct {logic [3:0] c; logic [20:0] a, f, l; logic [2:0] r;}
      snp_row_t;
   logic ref_clk, sys_rst, wp_n, psel, penable, pwrite, pready, pslverr, e;
   logic cmd_grant, grant_otp, powerup_busy, g_o;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] grant_cmd, g_c;
   logic [20:0] grant_addr, grant_last, g_a, g_l;
   logic [7:0] grant_data, g_d;
   int fails = 0, samples_checked = 0, g_n = 0, n, k, b;
   snp_row_t rows[7] = '{'{4'h3, 21'h012345, 21'h012300, 21'h0123FF, 3'h1},
      '{4'h4, 21'h1FF123, 21'h1FF000, 21'h1FFFFF, 3'h1},
      '{4'h5, 21'h018765, 21'h018000, 21'h01FFFF, 3'h1},
      '{4'h6, 21'h00ABCD, 21'h000000, 21'h00FFFF, 3'h1},
      '{4'h7, 21'h0A0000, 21'h000000, 21'h1FFFFF, 3'h1},
      '{4'hA, 21'h000100, 21'h0, 21'h0, 3'h6},
      '{4'hB, 21'h000005, 21'h0, 21'h0, 3'h1}};
   snp_protect #(.PU_CYCLES(8)) i_snp_protect (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wp_n(wp_n), .cmd_grant(cmd_grant),
      .grant_cmd(grant_cmd), .grant_addr(grant_addr),
      .grant_last(grant_last), .grant_data(grant_data),
      .grant_otp(grant_otp), .powerup_busy(powerup_busy));
   snp_host_model i_snp_host_model (.ref_clk(ref_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (cmd_grant === 1'b1) begin
         g_n <= g_n + 1;
         g_a <= grant_addr;
         g_l <= grant_last;
         g_d <= grant_data;
         g_o <= grant_otp;
         g_c <= grant_cmd;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input string s, input logic [31:0] x, input logic [31:0] y);
      samples_checked++;
      if (x !== y) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", s, x, y);
      end
   endtask
   task end_sim;
      fails = fails + i_snp_host_model.tmo;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_snp_host_model.xfer(w, a, d, q, e);
      if (i_snp_host_model.tmo != 0) end_sim();
   endtask
   // A bounded wait; the power-up interval is short in this bench.
   task pu_wait;
      int t;
      for (t = 0; powerup_busy !== 1'b0 && t < 100; t++) @(posedge ref_clk);
      if (t >= 100) begin
         fails++;
         end_sim();
      end
   endtask
   task run(input logic [3:0] c, input logic [20:0] a, input logic [7:0] d,
      input logic [2:0] r);
      bus(1'b1, `SNP_REG_ADDR, {11'h0, a});
      bus(1'b1, `SNP_REG_DATA, {24'h0, d});
      bus(1'b1, `SNP_REG_CMD, 32'h1);
      bus(1'b1, `SNP_REG_CMD, {28'h0, c});
      bus(1'b0, `SNP_REG_RESULT, 32'h0);
      chk("result", {29'h0, r}, q);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      wp_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      bus(1'b1, `SNP_REG_CMD, 32'h3);
      bus(1'b0, `SNP_REG_RESULT, 32'h0);
      chk("power-up result", 32'h5, q);
      pu_wait();
      for (n = 0; n < 3; n++) begin
         bus(1'b0, 12'(n * 4), 32'h0);
         chk("reset value", 32'h0, q);
      end
      bus(1'b0, 12'h020, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      $display("test reset done");
      for (n = 0; n < 7; n++) begin
         b = g_n;
         run(rows[n].c, rows[n].a, 8'h5A, rows[n].r);
         chk("grants", 32'(b + (rows[n].r == 3'h1)), 32'(g_n));
         if (rows[n].r == 3'h1) begin
            chk("data", rows[n].c > 4'h7 || rows[n].c == 4'h3 ? 32'h5A :
               32'hFF, {24'h0, g_d});
            chk("otp", {31'h0, rows[n].c == 4'hB}, {31'h0, g_o});
            chk("cmd", {28'h0, rows[n].c}, {28'h0, g_c});
            if (rows[n].c != 4'hB) begin
               chk("first", {11'h0, rows[n].f}, {11'h0, g_a});
               chk("last", {11'h0, rows[n].l}, {11'h0, g_l});
            end
         end
      end
      $display("test table done");
      bus(1'b1, `SNP_REG_CMD, 32'h3);
      bus(1'b0, `SNP_REG_RESULT, 32'h0);
      chk("enable cleared", 32'h2, q);
      bus(1'b1, `SNP_REG_CMD, 32'h1);
      bus(1'b1, `SNP_REG_CMD, 32'h303);
      bus(1'b0, `SNP_REG_RESULT, 32'h0);
      chk("framing", 32'h3, q);
      for (n = 0; n < 16; n++) begin
         run(4'h9, 21'h0, 8'(n), 3'h1);
         bus(1'b0, `SNP_REG_CTRL, 32'h0);
         chk("ctrl", 32'(n), q);
         k = n[2:0] > 5 ? 32 : n[2:0] == 0 ? 0 : 1 << (n[2:0] - 1);
         b = n < 8 ? 32 - k : k - 1;
         if (k > 0) run(4'h3, {5'(b), 16'h0}, 8'h5A, 3'h4);
         b = n < 8 ? 31 - k : k;
         if (k < 32) run(4'h3, {5'(b), 16'h0}, 8'h5A, 3'h1);
      end
      run(4'h9, 21'h0, 8'h0, 3'h1);
      $display("test protect range done");
      run(4'h8, 21'h050000, 8'h1, 3'h1);
      run(4'h3, 21'h05A000, 8'h5A, 3'h4);
      bus(1'b1, `SNP_REG_LOCKDN, 32'h20);
      run(4'h8, 21'h050000, 8'h0, 3'h7);
      bus(1'b0, `SNP_REG_LOCK, 32'h0);
      chk("lock kept", 32'h20, q);
      sys_rst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      pu_wait();
      bus(1'b0, `SNP_REG_LOCK, 32'h0);
      chk("lock after reset", 32'h0, q);
      $display("test lock done");
      wp_n <= 1'b0;
      run(4'h9, 21'h0, 8'h3, 3'h7);
      bus(1'b0, `SNP_REG_CTRL, 32'h0);
      chk("frozen size", 32'h0, {28'h0, q[3:0]});
      $display("test write protect done");
      end_sim();
   end
endmodule
`default_nettype wire
